// ### rtl/ssp_sram_port.sv
// Top level of a split-port burst SRAM port with double-rate write and read data.
// Assumes address, selects, masks and write data change in step with core_clk,
// with the falling-phase beat already captured into the *_fall ports.
//
// Function
// [RULE1] Write data is taken on both clock phases while a write burst runs.
// [RULE2] A low write select at the clock edge starts a write.
// [RULE3] A high write select leaves the array untouched and ignores write data.
// [RULE4] In 8-bit form mask 0 guards bits 3..0, mask 1 bits 7..4.
// [RULE5] Each lane mask is taken with the very beat it qualifies.
// [RULE6] A high nibble mask drops that nibble of the beat.
// [RULE7] In wider forms each byte mask guards one 9-bit lane.
// [RULE8] A high byte mask drops that lane of the beat.
// [RULE9] One address bus, taken at the clock edge, serves reads and writes.
// [RULE10] Address width is 19, 18 or 17 bits; each selects four words.
// [RULE11] The address is ignored for a port not selected that cycle.
// [RULE12] Read data leaves on both output clock phases, or core clock phases.
// [RULE13] With no read pending the read data drivers are off.
// [RULE14] A low read select at the clock edge starts a read.
// [RULE15] A read already running finishes its burst after deselect.
// [RULE16] Drivers turn off after the next output clock edge past the burst.
// [RULE17] Every read returns four consecutive words of the addressed location.
// [RULE18] Accesses start only on the core clock rising edge.
// [RULE19] The output clock pair times read data out of the device.
// [RULE20] A write carries four beats over the two cycles after its select.
// [RULE21] The controller never needs the address for both ports on one edge.
`timescale 1ns/1ns
module ssp_sram_port #(
  parameter int DATA_W = ssp_pkg::DATA_W_DEFAULT,
  parameter int ADDR_W = ssp_pkg::addr_width(DATA_W)
) (
  input logic core_clk,
  input logic reset_n,
  input logic out_clk,
  input logic single_clock_mode,
  input logic [ADDR_W-1:0] address,
  input logic write_port_select_n,
  input logic read_port_select_n,
  input logic [DATA_W-1:0] write_data_rise,
  input logic [DATA_W-1:0] write_data_fall,
  input logic [ssp_pkg::NIBBLE_MASK_W-1:0] nibble_write_mask_n_rise,
  input logic [ssp_pkg::NIBBLE_MASK_W-1:0] nibble_write_mask_n_fall,
  input logic [ssp_pkg::BYTE_MASK_W-1:0] byte_write_mask_n_rise,
  input logic [ssp_pkg::BYTE_MASK_W-1:0] byte_write_mask_n_fall,
  output logic [DATA_W-1:0] read_data_rise,
  output logic [DATA_W-1:0] read_data_fall,
  output logic read_data_oe
);
  localparam int LANE_W = ssp_pkg::lane_width(DATA_W);
  localparam int MASK_W = DATA_W / LANE_W;
  localparam int IDX_W = ADDR_W + ssp_pkg::BEAT_IDX_W;
  localparam int WORDS = 2 ** IDX_W;

  // ==========================================================================
  // Lane decoding helpers

  // Expands active-low lane masks into a per-bit write enable.
  function automatic logic [DATA_W-1:0] lane_enable(input logic [MASK_W-1:0] mask_n);
    logic [DATA_W-1:0] en;
    en = '0;
    for (int l = 0; l < MASK_W; l++) begin
      en[l*LANE_W +: LANE_W] = {LANE_W{~mask_n[l]}};
    end
    return en;
  endfunction

  // Keeps stored bits where the enable is low.
  function automatic logic [DATA_W-1:0] merge_word(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [DATA_W-1:0] en
  );
    return (old_word & ~en) | (new_word & en);
  endfunction

  // ==========================================================================
  // Storage and sequencing state
  logic [DATA_W-1:0] mem [0:WORDS-1];
  logic [ssp_pkg::BURST_LEN*DATA_W-1:0] burst_r;
  logic rd_tgl_r;
  ssp_pkg::ssp_burst_state_type wr_state_r;
  ssp_pkg::ssp_burst_state_type rd_state_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [MASK_W-1:0] wmask_rise_n;
  logic [MASK_W-1:0] wmask_fall_n;
  logic [DATA_W-1:0] wen_rise;
  logic [DATA_W-1:0] wen_fall;
  logic [IDX_W-1:0] wr_idx_rise;
  logic [IDX_W-1:0] wr_idx_fall;
  logic wr_accept;
  logic rd_accept;
  logic wr_beat;
  logic wr_upper;
  logic mode_meta_r;
  logic mode_sync_r;
  logic [1:0] mode_fill_r;
  logic mode_taken_r;
  logic mode_r;
  logic [DATA_W-1:0] core_q_rise;
  logic [DATA_W-1:0] core_q_fall;
  logic core_q_oe;
  logic [DATA_W-1:0] link_q_rise;
  logic [DATA_W-1:0] link_q_fall;
  logic link_q_oe;

  ssp_rd_if #(.DATA_W(DATA_W)) rd_bus ();

  // ==========================================================================
  // Write mask selection
  generate
    if (LANE_W == ssp_pkg::NIBBLE_W) begin : g_nibble
      assign wmask_rise_n = nibble_write_mask_n_rise[MASK_W-1:0]; // RULE4
      assign wmask_fall_n = nibble_write_mask_n_fall[MASK_W-1:0]; // RULE4
    end else begin : g_byte
      assign wmask_rise_n = byte_write_mask_n_rise[MASK_W-1:0]; // RULE7
      assign wmask_fall_n = byte_write_mask_n_fall[MASK_W-1:0]; // RULE7
    end
  endgenerate

  assign wen_rise = lane_enable(wmask_rise_n); // RULE5 RULE6 RULE8
  assign wen_fall = lane_enable(wmask_fall_n); // RULE5 RULE6 RULE8

  // ==========================================================================
  // Write sequencing
  assign wr_accept = !write_port_select_n && (wr_state_r != ssp_pkg::BURST_FIRST); // RULE2
  assign wr_beat = (wr_state_r == ssp_pkg::BURST_FIRST) ||
                   (wr_state_r == ssp_pkg::BURST_SECOND); // RULE3
  assign wr_upper = (wr_state_r == ssp_pkg::BURST_SECOND);
  assign wr_idx_rise = {wr_addr_r, wr_upper ? ssp_pkg::BEAT2 : ssp_pkg::BEAT0}; // RULE20
  assign wr_idx_fall = {wr_addr_r, wr_upper ? ssp_pkg::BEAT3 : ssp_pkg::BEAT1}; // RULE20

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_state_r <= ssp_pkg::BURST_IDLE;
      wr_addr_r <= '0;
    end else begin
      case (wr_state_r)
        ssp_pkg::BURST_IDLE, ssp_pkg::BURST_SECOND: begin
          if (wr_accept) begin
            wr_addr_r <= address; // RULE9 RULE10 RULE11
            wr_state_r <= ssp_pkg::BURST_FIRST; // RULE18
          end else begin
            wr_state_r <= ssp_pkg::BURST_IDLE; // RULE3
          end
        end
        ssp_pkg::BURST_FIRST: begin
          wr_state_r <= ssp_pkg::BURST_SECOND; // RULE20
        end
        default: begin
          wr_state_r <= ssp_pkg::BURST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Array access
  always_ff @(posedge core_clk) begin
    if (wr_beat) begin
      mem[wr_idx_rise] <= merge_word(mem[wr_idx_rise], write_data_rise, wen_rise); // RULE1
      mem[wr_idx_fall] <= merge_word(mem[wr_idx_fall], write_data_fall, wen_fall); // RULE1
    end
    if (rd_accept) begin
      for (int b = 0; b < ssp_pkg::BURST_LEN; b++) begin
        burst_r[b*DATA_W +: DATA_W] <= mem[{address, ssp_pkg::BEAT_IDX_W'(b)}]; // RULE17
      end
    end
  end

  // ==========================================================================
  // Read sequencing
  assign rd_accept = !read_port_select_n && (rd_state_r != ssp_pkg::BURST_FIRST); // RULE14

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_state_r <= ssp_pkg::BURST_IDLE;
      rd_tgl_r <= 1'b0;
    end else begin
      case (rd_state_r)
        ssp_pkg::BURST_IDLE, ssp_pkg::BURST_SECOND: begin
          if (rd_accept) begin
            rd_tgl_r <= ~rd_tgl_r; // RULE11 RULE18
            rd_state_r <= ssp_pkg::BURST_FIRST;
          end else begin
            rd_state_r <= ssp_pkg::BURST_IDLE;
          end
        end
        ssp_pkg::BURST_FIRST: begin
          rd_state_r <= ssp_pkg::BURST_SECOND; // RULE15
        end
        default: begin
          rd_state_r <= ssp_pkg::BURST_IDLE;
        end
      endcase
    end
  end

  assign rd_bus.burst_data = burst_r;
  assign rd_bus.req_tgl = rd_tgl_r;

  // ==========================================================================
  // Clock mode strap, caught once the synchroniser has filled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_meta_r <= 1'b0;
      mode_sync_r <= 1'b0;
      mode_fill_r <= 2'h0;
      mode_taken_r <= 1'b0;
      mode_r <= 1'b0;
    end else begin
      mode_meta_r <= single_clock_mode;
      mode_sync_r <= mode_meta_r;
      mode_fill_r <= {mode_fill_r[0], 1'b1};
      if (mode_fill_r[1] && !mode_taken_r) begin
        mode_r <= mode_sync_r;
        mode_taken_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Output sequencers on the output clock and on the core clock
  ssp_read_driver #(
    .DATA_W(DATA_W),
    .SAME_CLOCK(1'b0)
  ) u_link_driver (
    .drv_clk(out_clk),
    .reset_n(reset_n),
    .rd(rd_bus),
    .q_rise(link_q_rise),
    .q_fall(link_q_fall),
    .q_oe(link_q_oe)
  );

  ssp_read_driver #(
    .DATA_W(DATA_W),
    .SAME_CLOCK(1'b1)
  ) u_core_driver (
    .drv_clk(core_clk),
    .reset_n(reset_n),
    .rd(rd_bus),
    .q_rise(core_q_rise),
    .q_fall(core_q_fall),
    .q_oe(core_q_oe)
  );

  assign read_data_rise = mode_r ? core_q_rise : link_q_rise; // RULE12 RULE19
  assign read_data_fall = mode_r ? core_q_fall : link_q_fall; // RULE12 RULE19
  assign read_data_oe = mode_r ? core_q_oe : link_q_oe; // RULE13
endmodule

// ### rtl/ssp_pkg.sv
// Shared constants and types of the split-port burst SRAM port.
// Assumes a SystemVerilog compiler; nothing else depends on the surroundings.
package ssp_pkg;

  // ==========================================================================
  // Data and address widths
  localparam int DATA_W_X8 = 8;
  localparam int DATA_W_X9 = 9;
  localparam int DATA_W_X18 = 18;
  localparam int DATA_W_X36 = 36;
  localparam int DATA_W_DEFAULT = DATA_W_X36;
  localparam int ADDR_W_X8 = 19;
  localparam int ADDR_W_X18 = 18;
  localparam int ADDR_W_X36 = 17;

  // ==========================================================================
  // Write lanes
  localparam int NIBBLE_W = 4;
  localparam int BYTE_W = 9;
  localparam int NIBBLE_MASK_W = 2;
  localparam int BYTE_MASK_W = 4;

  // ==========================================================================
  // Burst layout
  localparam int BURST_LEN = 4;
  localparam int BEAT_IDX_W = 2;
  localparam logic [BEAT_IDX_W-1:0] BEAT0 = 2'h0;
  localparam logic [BEAT_IDX_W-1:0] BEAT1 = 2'h1;
  localparam logic [BEAT_IDX_W-1:0] BEAT2 = 2'h2;
  localparam logic [BEAT_IDX_W-1:0] BEAT3 = 2'h3;

  // ==========================================================================
  // Burst sequencing states, shared by write, read and output sequencers
  typedef enum logic [2:0] {
    BURST_IDLE = 3'h1,
    BURST_FIRST = 3'h2,
    BURST_SECOND = 3'h4
  } ssp_burst_state_type;

  // Address width that belongs to a data width.
  function automatic int addr_width(input int data_w);
    if (data_w == DATA_W_X36) begin
      return ADDR_W_X36;
    end
    if (data_w == DATA_W_X18) begin
      return ADDR_W_X18;
    end
    return ADDR_W_X8;
  endfunction

  // Width of one write lane for a data width.
  function automatic int lane_width(input int data_w);
    return (data_w == DATA_W_X8) ? NIBBLE_W : BYTE_W;
  endfunction

endpackage

// ### rtl/ssp_rd_if.sv
// Carrier of one read burst from the array side to an output sequencer.
// Assumes burst_data is held stable for two core_clk cycles after each toggle.
`timescale 1ns/1ns
interface ssp_rd_if #(
  parameter int DATA_W = ssp_pkg::DATA_W_DEFAULT
);
  logic [ssp_pkg::BURST_LEN*DATA_W-1:0] burst_data;
  logic req_tgl;

  modport src (
    output burst_data,
    output req_tgl
  );

  modport sink (
    input burst_data,
    input req_tgl
  );
endinterface

// ### rtl/ssp_read_driver.sv
// Output sequencer that drives one read burst as two double-rate cycles.
// Assumes burst_data is stable well past the toggle as seen in drv_clk.
`timescale 1ns/1ns
module ssp_read_driver #(
  parameter int DATA_W = ssp_pkg::DATA_W_DEFAULT,
  parameter bit SAME_CLOCK = 1'b0
) (
  input logic drv_clk,
  input logic reset_n,
  ssp_rd_if.sink rd,
  output logic [DATA_W-1:0] q_rise,
  output logic [DATA_W-1:0] q_fall,
  output logic q_oe
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic tgl_seen;
  logic tgl_prev_r;
  logic start;
  logic [2*DATA_W-1:0] tail_r;
  ssp_pkg::ssp_burst_state_type state_r;

  // ==========================================================================
  // Reset release aligned to this clock
  always_ff @(posedge drv_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Burst request detection
  generate
    if (SAME_CLOCK) begin : g_direct
      assign tgl_seen = rd.req_tgl;
    end else begin : g_sync
      logic tgl_meta_r;
      logic tgl_sync_r;
      always_ff @(posedge drv_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
          tgl_meta_r <= 1'b0;
          tgl_sync_r <= 1'b0;
        end else begin
          tgl_meta_r <= rd.req_tgl;
          tgl_sync_r <= tgl_meta_r;
        end
      end
      assign tgl_seen = tgl_sync_r;
    end
  endgenerate

  assign start = tgl_seen ^ tgl_prev_r;

  // ==========================================================================
  // Output sequencing
  always_ff @(posedge drv_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ssp_pkg::BURST_IDLE;
      tgl_prev_r <= 1'b0;
      q_rise <= '0;
      q_fall <= '0;
      q_oe <= 1'b0;
      tail_r <= '0;
    end else begin
      tgl_prev_r <= tgl_seen;
      case (state_r)
        ssp_pkg::BURST_IDLE, ssp_pkg::BURST_SECOND: begin
          if (start) begin
            q_rise <= rd.burst_data[0*DATA_W +: DATA_W]; // RULE12
            q_fall <= rd.burst_data[1*DATA_W +: DATA_W]; // RULE12
            tail_r <= rd.burst_data[2*DATA_W +: 2*DATA_W]; // RULE17
            q_oe <= 1'b1;
            state_r <= ssp_pkg::BURST_FIRST;
          end else begin
            q_oe <= 1'b0; // RULE16
            state_r <= ssp_pkg::BURST_IDLE; // RULE13
          end
        end
        ssp_pkg::BURST_FIRST: begin
          q_rise <= tail_r[DATA_W-1:0]; // RULE17
          q_fall <= tail_r[2*DATA_W-1:DATA_W]; // RULE17
          state_r <= ssp_pkg::BURST_SECOND; // RULE15
        end
        default: begin
          q_oe <= 1'b0;
          state_r <= ssp_pkg::BURST_IDLE;
        end
      endcase
    end
  end
endmodule

// ### dv/ssp_sram_port_assertions.sv
// Concurrent checks of the read port timing of ssp_sram_port.
// Assumes the mode strap only changes while reset_n is low.
`timescale 1ns/1ns
module ssp_sram_port_assertions (
  input logic core_clk,
  input logic reset_n,
  input logic out_clk,
  input logic single_clock_mode,
  input logic read_port_select_n,
  input logic read_data_oe
);
  // ==========================================================================
  // Helper logic
  logic [2:0] settle_r;
  logic first_r;
  logic acc;
  assign acc = single_clock_mode && (settle_r == 3'h4) && !read_port_select_n && !first_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_r <= 3'h0;
    end else if (settle_r != 3'h4) begin
      settle_r <= settle_r + 3'h1;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_r <= 1'b0;
    end else begin
      first_r <= acc;
    end
  end
  // ==========================================================================
  // Properties
  sequence s_two_beats;
    read_data_oe ##1 read_data_oe;
  endsequence
  property p_rd_start;
    @(posedge core_clk) disable iff (!reset_n) acc |-> ##2 s_two_beats;
  endproperty
  property p_rd_finish;
    @(posedge core_clk) disable iff (!reset_n) acc ##1 read_port_select_n |-> ##1 s_two_beats;
  endproperty
  property p_rd_end;
    @(posedge core_clk) disable iff (!reset_n) acc ##2 !acc |-> ##2 !read_data_oe;
  endproperty
  property p_rd_chain;
    @(posedge core_clk) disable iff (!reset_n) acc ##2 acc |-> ##2 s_two_beats;
  endproperty
  property p_rd_idle;
    @(posedge core_clk) disable iff (!reset_n)
      (settle_r == 3'h4 && single_clock_mode && read_data_oe) |-> $past(acc, 2) || $past(acc, 3);
  endproperty
  property p_rd_first;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(read_data_oe) && single_clock_mode |-> $past(acc, 2);
  endproperty
  property p_reset_quiet;
    @(posedge core_clk) disable iff (!reset_n) $rose(reset_n) |-> !read_data_oe;
  endproperty
  property p_dual_len;
    @(posedge out_clk) disable iff (!reset_n)
      !single_clock_mode && $rose(read_data_oe) |=> read_data_oe ##1 !read_data_oe;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read burst did not start");
  a_rd_finish: assert property (p_rd_finish) else $error("burst cut by deselect");
  a_rd_end: assert property (p_rd_end) else $error("drivers on after burst");
  a_rd_chain: assert property (p_rd_chain) else $error("chained burst broken");
  a_rd_idle: assert property (p_rd_idle) else $error("drivers on with no read");
  a_rd_first: assert property (p_rd_first) else $error("read began off edge");
  a_reset_quiet: assert property (p_reset_quiet) else $error("drivers on at reset");
  a_dual_len: assert property (p_dual_len) else $error("output clock burst length");
endmodule

bind ssp_sram_port ssp_sram_port_assertions u_chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .out_clk(out_clk),
  .single_clock_mode(single_clock_mode),
  .read_port_select_n(read_port_select_n),
  .read_data_oe(read_data_oe)
);

// ### dv/ssp_ctrl_model.sv
// Memory controller model: drives selects, address, masks and write data,
// and collects read beats. Assumes it faces the pins of ssp_sram_port.
`timescale 1ns/1ns
module ssp_ctrl_model #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
) (
  input logic core_clk,
  input logic out_clk,
  input logic single_clock_mode,
  output logic [ADDR_W-1:0] address,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [DATA_W-1:0] write_data_rise,
  output logic [DATA_W-1:0] write_data_fall,
  output logic [3:0] mask_rise_n,
  output logic [3:0] mask_fall_n,
  input logic [DATA_W-1:0] read_data_rise,
  input logic [DATA_W-1:0] read_data_fall,
  input logic read_data_oe
);
  logic [DATA_W-1:0] rx_q[$];
  initial begin
    address = '0;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    write_data_rise = '0;
    write_data_fall = '0;
    mask_rise_n = 4'hF;
    mask_fall_n = 4'hF;
  end
  // Read beats are taken mid-cycle of whichever clock times them.
  always @(negedge core_clk) begin
    if (single_clock_mode && read_data_oe) begin
      rx_q.push_back(read_data_rise);
      rx_q.push_back(read_data_fall);
    end
  end
  always @(negedge out_clk) begin
    if (!single_clock_mode && read_data_oe) begin
      rx_q.push_back(read_data_rise);
      rx_q.push_back(read_data_fall);
    end
  end
  // One write: select cycle, then two cycles of beats with their masks.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [4*DATA_W-1:0] d,
                    input logic [15:0] m, input logic sel_n);
    @(negedge core_clk);
    write_port_select_n <= sel_n;
    address <= a;
    @(negedge core_clk);
    write_port_select_n <= 1'b1;
    address <= ~a;
    write_data_rise <= d[0+:DATA_W];
    write_data_fall <= d[DATA_W+:DATA_W];
    mask_rise_n <= m[3:0];
    mask_fall_n <= m[7:4];
    @(negedge core_clk);
    write_data_rise <= d[2*DATA_W+:DATA_W];
    write_data_fall <= d[3*DATA_W+:DATA_W];
    mask_rise_n <= m[11:8];
    mask_fall_n <= m[15:12];
    @(negedge core_clk);
    write_data_rise <= ~d[2*DATA_W+:DATA_W];
    write_data_fall <= ~d[3*DATA_W+:DATA_W];
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(negedge core_clk);
    read_port_select_n <= 1'b0;
    address <= a;
    @(negedge core_clk);
    read_port_select_n <= 1'b1;
    address <= ~a;
  endtask
endmodule

// ### dv/tb_ssp_sram_port.sv
// Testbench of ssp_sram_port in its 36-bit form with a controller model.
// Assumes the model's tasks are called one at a time.
`timescale 1ns/1ns
module tb_ssp_sram_port;
  localparam int W = ssp_pkg::DATA_W_X36;
  localparam int AW = ssp_pkg::ADDR_W_X36;
  logic core_clk = 1'b0;
  logic out_clk = 1'b0;
  logic reset_n = 1'b0;
  logic single_clock_mode = 1'b1;
  logic [AW-1:0] address;
  logic wps_n, rps_n, oe;
  logic [W-1:0] wd_r, wd_f, rd_r, rd_f;
  logic [3:0] bm_r, bm_f;
  logic [W-1:0] exp_mem[int];
  logic [W-1:0] exp_q[$];
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #2;
    forever #3 out_clk = ~out_clk;
  end
  ssp_sram_port #(.DATA_W(W)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .out_clk(out_clk),
    .single_clock_mode(single_clock_mode), .address(address),
    .write_port_select_n(wps_n), .read_port_select_n(rps_n),
    .write_data_rise(wd_r), .write_data_fall(wd_f),
    .nibble_write_mask_n_rise(bm_r[1:0]), .nibble_write_mask_n_fall(bm_f[1:0]),
    .byte_write_mask_n_rise(bm_r), .byte_write_mask_n_fall(bm_f),
    .read_data_rise(rd_r), .read_data_fall(rd_f), .read_data_oe(oe));
  ssp_ctrl_model #(.DATA_W(W), .ADDR_W(AW)) ctrl (
    .core_clk(core_clk), .out_clk(out_clk), .single_clock_mode(single_clock_mode),
    .address(address), .write_port_select_n(wps_n), .read_port_select_n(rps_n),
    .write_data_rise(wd_r), .write_data_fall(wd_f), .mask_rise_n(bm_r),
    .mask_fall_n(bm_f), .read_data_rise(rd_r), .read_data_fall(rd_f),
    .read_data_oe(oe));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [W-1:0] seen, input logic [W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic do_reset(input logic mode);
    @(negedge core_clk);
    reset_n = 1'b0;
    single_clock_mode = mode;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
  function automatic logic [4*W-1:0] patt(input logic [W-1:0] s);
    return {s + 36'h3, s + 36'h2, s + 36'h1, s};
  endfunction
  task automatic wr(input logic [AW-1:0] a, input logic [4*W-1:0] d,
                    input logic [15:0] m, input logic sel_n);
    logic [W-1:0] w;
    ctrl.wr(a, d, m, sel_n);
    for (int b = 0; b < 4; b++) begin
      w = exp_mem.exists(a * 4 + b) ? exp_mem[a * 4 + b] : '0;
      for (int l = 0; l < 4; l++) begin
        if (!sel_n && !m[b * 4 + l]) begin
          w[l*9+:9] = d[b*W+l*9+:9];
        end
      end
      exp_mem[a * 4 + b] = w;
    end
  endtask
  task automatic rd(input logic [AW-1:0] a);
    for (int b = 0; b < 4; b++) begin
      exp_q.push_back(exp_mem[a * 4 + b]);
    end
    ctrl.rd(a);
  endtask
  task automatic flush();
    repeat (6) @(negedge core_clk);
    check("read count", W'(ctrl.rx_q.size()), W'(exp_q.size()));
    foreach (exp_q[i]) check("read word", ctrl.rx_q[i], exp_q[i]);
    check("drivers idle", W'(oe), '0);
    exp_q.delete();
    ctrl.rx_q.delete();
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_write_read();
    wr(17'h00005, patt(36'hA_1234_5670), 16'h0000, 1'b0);
    rd(17'h00005);
    flush();
  endtask
  task automatic t_masks();
    wr(17'h1FFFF, patt(36'h1_1111_1110), 16'h0000, 1'b0);
    wr(17'h1FFFF, patt(36'hE_EEEE_EEE0), 16'h7BDE, 1'b0);
    rd(17'h1FFFF);
    flush();
  endtask
  task automatic t_deselect();
    wr(17'h00005, patt(36'h5_5555_5550), 16'h0000, 1'b1);
    rd(17'h00005);
    flush();
  endtask
  task automatic t_back_to_back();
    rd(17'h00005);
    rd(17'h1FFFF);
    flush();
  endtask
  task automatic t_dual_clock();
    do_reset(1'b0);
    wr(17'h00AAA, patt(36'h3_C3C3_C3C0), 16'h0000, 1'b0);
    rd(17'h00AAA);
    flush();
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    do_reset(1'b1);
    t_write_read();
    t_masks();
    t_deselect();
    t_back_to_back();
    t_dual_clock();
    end_sim();
  end
endmodule
